// file: psqr_pkg.sv
package psqr_pkg;

  // register addresses (printed offsets, register port is direct)
  localparam logic [15:0] PSQR_ADDR_SQI      = 16'h0871;
  localparam logic [15:0] PSQR_ADDR_PMA_CTL1 = 16'h1000;
  localparam logic [15:0] PSQR_ADDR_PMA_STS1 = 16'h1001;
  localparam logic [15:0] PSQR_ADDR_PMA_STS2 = 16'h1007;
  localparam logic [15:0] PSQR_ADDR_EXT_AB1  = 16'h100b;
  localparam logic [15:0] PSQR_ADDR_EXT_AB2  = 16'h1012;
  localparam logic [15:0] PSQR_ADDR_PMA_CTL2 = 16'h1834;
  localparam logic [15:0] PSQR_ADDR_IRQ_STS  = 16'h1f00;
  localparam logic [15:0] PSQR_ADDR_IRQ_MASK = 16'h1f01;

  // field positions
  localparam int PSQR_SQI_CUR_LSB   = 1;
  localparam int PSQR_SQI_WORST_LSB = 5;
  localparam int PSQR_CTL1_RESET    = 15;
  localparam int PSQR_CTL1_LOOP     = 0;
  localparam int PSQR_STS1_LINK     = 2;
  localparam int PSQR_CTL2_FIXED    = 15;
  localparam int PSQR_CTL2_ROLE     = 14;

  // reset and constant values
  localparam logic [15:0] PSQR_STS2_VALUE  = 16'h003d;
  localparam logic [15:0] PSQR_EXT_AB1_VAL = 16'h0800;
  localparam logic [15:0] PSQR_EXT_AB2_VAL = 16'h0001;
  localparam logic [15:0] PSQR_CTL2_RESET  = 16'h8000;
  localparam logic [15:0] PSQR_ZERO        = 16'h0000;

  // interrupt status bits
  localparam int PSQR_IRQ_W     = 3;
  localparam int PSQR_IRQ_LINK  = 0;
  localparam int PSQR_IRQ_WORSE = 1;
  localparam int PSQR_IRQ_CHG   = 2;

endpackage

// file: psqr_regs.sv
`timescale 1ns/1ps
// Contract
// [RULE_01] sqi register: current grade bits 3-1, worst since last read 7-5
// [RULE_02] control-one bit 15 drives the medium attach reset, resets to zero
// [RULE_03] control-one bit 0 enables medium attach loopback, resets to zero
// [RULE_04] link status bit 2 read-only, mirrors link monitor verdict
// [RULE_05] type status bits 5-0 read 111101b
// [RULE_06] extended ability one bit 11 reads one
// [RULE_07] extended ability two reads 0001h
// [RULE_08] control-two bit 15 reads one, bit 14 role select, strap reset
// [RULE_09] reserved bits read zero, writes to them ignored
module psqr_regs
  import psqr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // status inputs from the datapath
  input  wire logic [2:0]  sqi_grade,
  input  wire logic        link_up,
  input  wire logic        role_strap,
  // control outputs
  output logic             medium_attach_reset,
  output logic             medium_attach_loopback,
  output logic             role_master_select,
  // interrupt
  output logic             irq
);

  typedef struct packed {
    logic [15:0]           rdata;
    logic                  pma_rst;
    logic                  pma_loop;
    logic                  role;
    logic                  strap_done;
    logic [2:0]            sqi_cur;
    logic                  link;
    logic [PSQR_IRQ_W-1:0] irq_sts;
    logic [PSQR_IRQ_W-1:0] irq_mask;
  } psqr_state_t;

  psqr_state_t st_reg;
  psqr_state_t st_next;

  logic [2:0] worst_grade;
  logic       worsened;
  logic       sqi_read;

  // a read of the sqi register restarts worst tracking
  assign sqi_read = reg_rd && (reg_addr == PSQR_ADDR_SQI);

  psqr_worst_track u_worst (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .grade    (sqi_grade),
    .restart  (sqi_read),
    .worst    (worst_grade),
    .worsened (worsened)
  );

  // read mux, unmapped addresses read zero
  function automatic logic [15:0] read_word(input logic [15:0] a, input psqr_state_t s,
                                            input logic [2:0] w);
    logic [15:0] v;
    v = PSQR_ZERO;
    unique case (a)
      PSQR_ADDR_SQI: begin
        v[PSQR_SQI_WORST_LSB +: 3] = w;                  // [RULE_01]
        v[PSQR_SQI_CUR_LSB +: 3]   = s.sqi_cur;          // [RULE_01]
      end
      PSQR_ADDR_PMA_CTL1: begin
        v[PSQR_CTL1_RESET] = s.pma_rst;                  // [RULE_02]
        v[PSQR_CTL1_LOOP]  = s.pma_loop;                 // [RULE_03]
      end
      PSQR_ADDR_PMA_STS1: v[PSQR_STS1_LINK] = s.link;    // [RULE_04]
      PSQR_ADDR_PMA_STS2: v = PSQR_STS2_VALUE;           // [RULE_05]
      PSQR_ADDR_EXT_AB1:  v = PSQR_EXT_AB1_VAL;          // [RULE_06]
      PSQR_ADDR_EXT_AB2:  v = PSQR_EXT_AB2_VAL;          // [RULE_07]
      PSQR_ADDR_PMA_CTL2: begin
        v[PSQR_CTL2_FIXED] = 1'b1;                       // [RULE_08]
        v[PSQR_CTL2_ROLE]  = s.role;                     // [RULE_08]
      end
      PSQR_ADDR_IRQ_STS:  v[PSQR_IRQ_W-1:0] = s.irq_sts;
      PSQR_ADDR_IRQ_MASK: v[PSQR_IRQ_W-1:0] = s.irq_mask;
      default:            v = PSQR_ZERO;                 // [RULE_09]
    endcase
    return v;
  endfunction

  // next-state logic
  always_comb begin
    logic [PSQR_IRQ_W-1:0] ev;
    ev = '0;
    st_next = st_reg;
    st_next.sqi_cur = sqi_grade;
    st_next.link    = link_up;                           // [RULE_04]
    // capture the strap once, after reset release
    if (!st_reg.strap_done) begin
      st_next.role       = role_strap;                   // [RULE_08]
      st_next.strap_done = 1'b1;
    end
    // register writes, reserved bits ignored
    if (reg_wr) begin
      unique case (reg_addr)
        PSQR_ADDR_PMA_CTL1: begin
          st_next.pma_rst  = reg_wdata[PSQR_CTL1_RESET]; // [RULE_02]
          st_next.pma_loop = reg_wdata[PSQR_CTL1_LOOP];  // [RULE_03]
        end
        PSQR_ADDR_PMA_CTL2: begin
          st_next.role       = reg_wdata[PSQR_CTL2_ROLE]; // [RULE_08]
          st_next.strap_done = 1'b1;
        end
        PSQR_ADDR_IRQ_STS:
          st_next.irq_sts = st_reg.irq_sts & ~reg_wdata[PSQR_IRQ_W-1:0];
        PSQR_ADDR_IRQ_MASK:
          st_next.irq_mask = reg_wdata[PSQR_IRQ_W-1:0];
        default: ;                                       // [RULE_09]
      endcase
    end
    // events: set wins over write-one-to-clear
    ev[PSQR_IRQ_LINK]  = (link_up != st_reg.link);
    ev[PSQR_IRQ_WORSE] = worsened;
    ev[PSQR_IRQ_CHG]   = (sqi_grade != st_reg.sqi_cur);
    st_next.irq_sts = st_next.irq_sts | ev;
    // read data one cycle after the strobe
    st_next.rdata = reg_rd ? read_word(reg_addr, st_reg, worst_grade) : PSQR_ZERO;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign reg_rdata              = st_reg.rdata;
  assign medium_attach_reset    = st_reg.pma_rst;        // [RULE_02]
  assign medium_attach_loopback = st_reg.pma_loop;       // [RULE_03]
  assign role_master_select     = st_reg.role;           // [RULE_08]
  assign irq                    = |(st_reg.irq_sts & st_reg.irq_mask);

endmodule

// file: psqr_regs_monitor.sv
`timescale 1ns/1ps
// port checks of the register bank
module psqr_monitor (
  // watched ports
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        medium_attach_reset,
  input wire logic        medium_attach_loopback,
  input wire logic        role_master_select
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // read data and control outputs against the strobes
  property p_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_rst; $past(reg_wr && reg_addr == 16'h1000) |-> medium_attach_reset == $past(reg_wdata[15]); endproperty
  a_rst: assert property (p_rst) else $error("reset bit");
  property p_lpb; $past(reg_wr && reg_addr == 16'h1000) |-> medium_attach_loopback == $past(reg_wdata[0]); endproperty
  a_lpb: assert property (p_lpb) else $error("loopback bit");
  property p_typ; $past(reg_rd && reg_addr == 16'h1007) |-> reg_rdata == 16'h003d; endproperty
  a_typ: assert property (p_typ) else $error("type field");
  property p_ab1; $past(reg_rd && reg_addr == 16'h100b) |-> reg_rdata == 16'h0800; endproperty
  a_ab1: assert property (p_ab1) else $error("ability one");
  property p_ab2; $past(reg_rd && reg_addr == 16'h1012) |-> reg_rdata == 16'h0001; endproperty
  a_ab2: assert property (p_ab2) else $error("ability two");
  property p_ctl2; $past(reg_rd && reg_addr == 16'h1834) |-> reg_rdata == {1'b1, $past(role_master_select), 14'h0000}; endproperty
  a_ctl2: assert property (p_ctl2) else $error("control two");
  property p_sqi; $past(reg_rd && reg_addr == 16'h0871) |-> reg_rdata[15:8] == 8'h00 && !reg_rdata[4] && !reg_rdata[0]; endproperty
  a_sqi: assert property (p_sqi) else $error("quality spare bits");
endmodule
bind psqr_regs psqr_monitor mon (.*);

// file: psqr_worst_track.sv
`timescale 1ns/1ps
// worst-grade tracker: lower grade is worse, restarts on read
module psqr_worst_track
  import psqr_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // grade input and restart
  input  wire logic [2:0] grade,
  input  wire logic       restart,
  // result
  output logic [2:0]      worst,
  output logic            worsened
);

  typedef struct packed {
    logic [2:0] worst;
    logic       valid;
  } psqr_wt_state_t;

  psqr_wt_state_t st_reg;
  psqr_wt_state_t st_next;

  // track minimum grade since restart
  always_comb begin
    st_next = st_reg;
    if (restart) begin
      st_next.worst = grade;
      st_next.valid = 1'b1;
    end else if (!st_reg.valid || grade < st_reg.worst) begin
      st_next.worst = grade;
      st_next.valid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // worst includes the grade present at the read edge
  assign worst    = (st_reg.valid && st_reg.worst < grade) ? st_reg.worst : grade;
  assign worsened = st_reg.valid && !restart && (grade < st_reg.worst);

endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import psqr_pkg::*;
  // design ports and bench state
  logic        clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, link_up = 1'b0, role_strap = 1'b1;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, r;
  logic [2:0]  sqi_grade = 3'h5, g;
  logic        medium_attach_reset, medium_attach_loopback, role_master_select, irq;
  int          error_cnt = 0, checks = 0;
  logic [15:0] ro_addr[5] = '{16'h1007, 16'h100b, 16'h1012, 16'h1001, 16'h0002};
  logic [15:0] ro_val[5] = '{16'h003d, 16'h0800, 16'h0001, 16'h0000, 16'h0000};
  always #5 clk_sys = ~clk_sys;
  psqr_regs dut (.*);
  // compare and count
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one write cycle
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // one read cycle, data looked at in the following cycle
  task automatic rd(logic [15:0] a, logic [15:0] e, logic [15:0] m = 16'hffff);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  // verdict
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    r = 16'($urandom(99));
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wr(ro_addr[i], 16'($urandom));
      rd(ro_addr[i], ro_val[i]);
    end
    rd(16'h1834, 16'hc000);
    $display("readout test done");
    repeat (4) begin
      r = 16'($urandom);
      wr(16'h1000, r);
      rd(16'h1000, r & 16'h8001);
      chk({14'h0000, medium_attach_reset, medium_attach_loopback}, {14'h0000, r[15], r[0]});
    end
    wr(16'h1834, 16'($urandom & 16'hbfff));
    rd(16'h1834, 16'h8000);
    $display("control test done");
    rd(16'h0871, 16'h00aa);
    g = 3'($urandom_range(6, 2));
    repeat (3) @(posedge clk_sys);
    sqi_grade <= g;
    repeat (3) @(posedge clk_sys);
    sqi_grade <= g - 3'h2;
    repeat (3) @(posedge clk_sys);
    sqi_grade <= 3'h7;
    rd(16'h0871, {8'h00, g - 3'h2, 1'b0, 3'h7, 1'b0});
    rd(16'h0871, 16'h00ee);
    $display("quality test done");
    rd(16'h1f00, 16'h0006);
    chk({15'h0000, irq}, 16'h0000);
    wr(16'h1f01, 16'h0007);
    #1 chk({15'h0000, irq}, 16'h0001);
    wr(16'h1f00, 16'h0006);
    #1 chk({15'h0000, irq}, 16'h0000);
    @(posedge clk_sys);
    link_up <= 1'b1;
    rd(16'h1001, 16'h0004);
    chk({15'h0000, irq}, 16'h0001);
    $display("interrupt test done");
    finish_test;
  end
endmodule
